// ### design/ths_pkg.sv
/*
  ths_pkg: shared constants and types of the track/hold sequencer.
  Assumes a 32-bit APB register bus and a 20 MHz system clock.
*/
package ths_pkg;

  // register byte offsets
  localparam logic [7:0] THS_CTRL_ADDR   = 8'h00;
  localparam logic [7:0] THS_HCNT_ADDR   = 8'h04;
  localparam logic [7:0] THS_STAT_ADDR   = 8'h08;
  localparam logic [7:0] THS_IRQS_ADDR   = 8'h0C;
  localparam logic [7:0] THS_IRQM_ADDR   = 8'h10;

  // control register fields
  localparam int THS_CTRL_OP_LSB   = 0;
  localparam int THS_CTRL_SRC_LSB  = 2;
  localparam int THS_CTRL_SEND_LSB = 4;
  localparam int THS_CTRL_SIMPLE   = 6;

  // status register fields
  localparam int THS_STAT_HOLD   = 0;
  localparam int THS_STAT_ACTIVE = 1;
  localparam int THS_STAT_BAD    = 2;
  localparam int THS_STAT_RSV    = 3;
  localparam int THS_STAT_REM    = 8;

  // interrupt status and mask bits
  localparam int THS_IRQ_HOLD  = 0;
  localparam int THS_IRQ_TRACK = 1;
  localparam int THS_IRQ_ERR   = 2;
  localparam int THS_IRQ_W     = 3;

  // reset values
  localparam logic [6:0]  THS_CTRL_RST = 7'h00;
  localparam logic [8:0]  THS_HCNT_RST = 9'h001;
  localparam logic [2:0]  THS_IRQM_RST = 3'h0;

  // hold entry count limits
  localparam logic [8:0]  THS_HCNT_MIN = 9'h001;
  localparam logic [8:0]  THS_HCNT_MAX = 9'h100;

  // operation select, control source and forwarding encodings
  localparam logic [1:0] THS_OP_NONE   = 2'h0;
  localparam logic [1:0] THS_OP_SINGLE = 2'h1;
  localparam logic [1:0] THS_OP_SCAN   = 2'h2;
  localparam logic [1:0] THS_SRC_CNT   = 2'h0;
  localparam logic [1:0] THS_SRC_EXT   = 2'h1;
  localparam logic [1:0] THS_SRC_BUS   = 2'h2;
  localparam logic [1:0] THS_SEND_NONE = 2'h0;
  localparam logic [1:0] THS_SEND_LOC  = 2'h1;
  localparam logic [1:0] THS_SEND_BUS  = 2'h2;

  // number of synchronised pins
  localparam int THS_NSYNC = 6;

  typedef enum logic {THS_TRACK, THS_HOLD} ths_state_t;

endpackage : ths_pkg

// ### design/ths_sync.sv
/*
  ths_sync: two-flop synchroniser for a group of pin levels.
  Assumes the inputs are asynchronous levels; only the second stage is read.
*/
module ths_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk_sys_i,
  input  wire logic         rst_n_i,
  // levels
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta   <= '0;
      sync_o <= '0;
    end else begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end

endmodule // ths_sync

// ### design/ths_entry_cnt.sv
/*
  ths_entry_cnt: down counter of scan-list entries still to pass in hold.
  Assumes load and dec come from logic on the same clock.
*/
module ths_entry_cnt (
  // clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       rst_n_i,
  // control
  input  wire logic       load_i,
  input  wire logic [8:0] load_val_i,
  input  wire logic       dec_i,
  // count
  output logic      [8:0] remain_o
);

  // load wins over a decrement in the same cycle
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      remain_o <= 9'h000;
    end else if (load_i) begin
      remain_o <= load_val_i;
    end else if (dec_i && remain_o != 9'h000) begin
      remain_o <= remain_o - 9'h001;
    end
  end

endmodule // ths_entry_cnt

// ### design/ths_top.sv
/*
  ths_top: track/hold sequencer with APB registers, source selection,
  forwarding of the control signal and scan-entry hold counting.
  Assumes all pin inputs are asynchronous and a single 20 MHz clock.
*/
// Notes on behaviour
// - operation none releases counter and trigger line
// - single and scan modes follow chosen source
// - source zero: host counter drives, reserved
// - source one: external pin, counter reserved
// - scan with external pin clocks scan timer
// - source two: follow backplane trigger line
// - forward one: drive counter line and pin, except whichever of them is the source
// - forward two: drive line, second driver errors
// - operation none ignores source and forwarding
// - hold entry count accepts 1 to 256
// - single mode: low tracks, high holds
// - scan mode holds on control rising edge
// - external rising edge also starts a scan
// - track again after counted scan entries
// - simple host: track each interval, no external
// - relay works even when not in scan list
module ths_top
  import ths_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // host counter line
  input  wire logic        scan_counter_output_i,
  output logic             scan_counter_output_o,
  output logic             scan_counter_output_oe_o,
  output logic             counter_reserved_o,
  // external hold pin
  input  wire logic        external_hold_input_i,
  output logic             external_hold_input_o,
  output logic             external_hold_input_oe_o,
  // backplane trigger line
  input  wire logic        bus_trig_i,
  input  wire logic        bus_trig_busy_i,
  output logic             bus_trig_o,
  output logic             bus_trig_oe_o,
  // scan sequencing from the host
  input  wire logic        entry_enable_i,
  input  wire logic        scan_done_i,
  output logic             scan_clk_o,
  output logic             scan_start_o,
  // analog front end and interrupt
  output logic             hold_o,
  output logic             irq_o
);

  logic [6:0]            ctrl;
  logic [8:0]            hold_count;
  logic [THS_IRQ_W-1:0]  irq_stat;
  logic [THS_IRQ_W-1:0]  irq_mask;
  logic [THS_NSYNC-1:0]  pins;
  logic [1:0]            op;
  logic [1:0]            src;
  logic [1:0]            send;
  logic                  simple;
  logic                  cnt_s;
  logic                  ext_s;
  logic                  bus_s;
  logic                  busy_s;
  logic                  ent_s;
  logic                  done_s;
  logic                  cfg_bad;
  logic                  cfg_bad_q;
  logic                  active;
  logic                  ctl;
  logic                  ctl_q;
  logic                  ent_q;
  logic                  done_q;
  logic                  ctl_rise;
  logic                  ent_fall;
  logic                  done_rise;
  logic                  cnt_load;
  logic                  cnt_dec;
  logic [8:0]            remain;
  logic                  acc;
  logic                  wr;
  logic [THS_IRQ_W-1:0]  irq_ev;
  ths_state_t            state;
  ths_state_t            next_state;

  // every pin passes two flops before any logic sees it
  ths_sync #(
    .W (THS_NSYNC)
  ) u_sync (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .async_i   ({scan_done_i, entry_enable_i, bus_trig_busy_i,
                 bus_trig_i, external_hold_input_i, scan_counter_output_i}),
    .sync_o    (pins)
  );

  assign {done_s, ent_s, busy_s, bus_s, ext_s, cnt_s} = pins;

  // configuration fields
  assign op     = ctrl[THS_CTRL_OP_LSB +: 2];
  assign src    = ctrl[THS_CTRL_SRC_LSB +: 2];
  assign send   = ctrl[THS_CTRL_SEND_LSB +: 2];
  assign simple = ctrl[THS_CTRL_SIMPLE];

  // illegal combinations leave the block released; none is never bad
  always_comb begin
    cfg_bad = 1'b0;
    if (op != THS_OP_NONE) begin
      if (op == 2'h3 || src == 2'h3 || send == 2'h3) begin
        cfg_bad = 1'b1;
      end
      if (simple && src == THS_SRC_EXT) begin
        cfg_bad = 1'b1;
      end
      if (send == THS_SEND_BUS && src != THS_SRC_BUS && busy_s) begin
        cfg_bad = 1'b1;
      end
    end
  end

  assign active = (op != THS_OP_NONE) && !cfg_bad;

  // control source selection
  always_comb begin
    case (src)
      THS_SRC_CNT: ctl = cnt_s;
      THS_SRC_EXT: ctl = ext_s;
      THS_SRC_BUS: ctl = bus_s;
      default:     ctl = 1'b0;
    endcase
  end

  // edge history of the synchronised levels and of cfg_bad
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctl_q     <= 1'b0;
      ent_q     <= 1'b0;
      done_q    <= 1'b0;
      cfg_bad_q <= 1'b0;
    end else begin
      ctl_q     <= ctl;
      ent_q     <= ent_s;
      done_q    <= done_s;
      cfg_bad_q <= cfg_bad;
    end
  end

  assign ctl_rise  = ctl && !ctl_q;
  assign ent_fall  = !ent_s && ent_q;
  assign done_rise = done_s && !done_q;

  // track/hold decision
  always_comb begin
    next_state = THS_TRACK;
    if (active) begin
      case (op)
        THS_OP_SINGLE: begin
          next_state = ctl ? THS_HOLD : THS_TRACK;
        end
        THS_OP_SCAN: begin
          case (state)
            THS_TRACK: begin
              next_state = ctl_rise ? THS_HOLD : THS_TRACK;
            end
            THS_HOLD: begin
              next_state = THS_HOLD;
              if (simple) begin
                if (done_rise) begin
                  next_state = THS_TRACK;
                end
              end else if (ent_fall && remain == THS_HCNT_MIN) begin
                next_state = THS_TRACK;
              end
            end
            default: next_state = THS_TRACK;
          endcase
        end
        default: next_state = THS_TRACK;
      endcase
    end
  end

  // state and the hold output move together
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= THS_TRACK;
      hold_o <= 1'b0;
    end else begin
      state <= next_state;
      hold_o <= (next_state == THS_HOLD);
    end
  end

  // each hold entry rearms the count of scan-list entries
  assign cnt_load = (state == THS_TRACK) && (next_state == THS_HOLD);
  assign cnt_dec  = (state == THS_HOLD) && ent_fall;

  ths_entry_cnt u_entry_cnt (
    .clk_sys_i  (clk_sys_i),
    .rst_n_i    (rst_n_i),
    .load_i     (cnt_load),
    .load_val_i (hold_count),
    .dec_i      (cnt_dec),
    .remain_o   (remain)
  );

  // forwarding of the control signal; a released pin is never driven
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scan_counter_output_o    <= 1'b0;
      scan_counter_output_oe_o <= 1'b0;
      external_hold_input_o    <= 1'b0;
      external_hold_input_oe_o <= 1'b0;
      bus_trig_o               <= 1'b0;
      bus_trig_oe_o            <= 1'b0;
      counter_reserved_o       <= 1'b0;
    end else begin
      scan_counter_output_o    <= ctl;
      external_hold_input_o    <= ctl;
      bus_trig_o               <= ctl;
      // a source never drives back onto itself
      scan_counter_output_oe_o <= active && send == THS_SEND_LOC && src != THS_SRC_CNT;
      external_hold_input_oe_o <= active && send == THS_SEND_LOC && src != THS_SRC_EXT;
      bus_trig_oe_o            <= active && send == THS_SEND_BUS && src != THS_SRC_BUS;
      // counter is claimed whenever its line carries our signal
      counter_reserved_o       <= active && (src != THS_SRC_BUS || send == THS_SEND_LOC);
    end
  end

  // scan timer clock and scan start, independent of scan-list presence
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scan_clk_o   <= 1'b0;
      scan_start_o <= 1'b0;
    end else begin
      scan_clk_o   <= active && op == THS_OP_SCAN && src != THS_SRC_CNT && ctl;
      scan_start_o <= active && op == THS_OP_SCAN && src == THS_SRC_EXT && ctl_rise;
    end
  end

  // apb: answer comes one cycle into the access phase
  assign acc = psel && penable && !pready;
  assign wr  = psel && penable && pready && pwrite;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= acc;
      pslverr <= 1'b0;
      if (acc) begin
        prdata <= 32'h00000000;
        case (paddr)
          THS_CTRL_ADDR: prdata[6:0] <= ctrl;
          THS_HCNT_ADDR: prdata[8:0] <= hold_count;
          THS_STAT_ADDR: begin
            prdata[THS_STAT_HOLD]       <= hold_o;
            prdata[THS_STAT_ACTIVE]     <= active;
            prdata[THS_STAT_BAD]        <= cfg_bad;
            prdata[THS_STAT_RSV]        <= counter_reserved_o;
            prdata[THS_STAT_REM +: 9]   <= remain;
          end
          THS_IRQS_ADDR: prdata[THS_IRQ_W-1:0] <= irq_stat;
          THS_IRQM_ADDR: prdata[THS_IRQ_W-1:0] <= irq_mask;
          default:       pslverr <= 1'b1; // unmapped reads zero with error
        endcase
      end
    end
  end

  // writable registers; out of range counts are dropped, old value kept
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl       <= THS_CTRL_RST;
      hold_count <= THS_HCNT_RST;
      irq_mask   <= THS_IRQM_RST;
    end else if (wr) begin
      case (paddr)
        THS_CTRL_ADDR: ctrl <= pwdata[6:0];
        THS_HCNT_ADDR: begin
          if (pwdata[31:9] == 23'h000000 && pwdata[8:0] >= THS_HCNT_MIN
              && pwdata[8:0] <= THS_HCNT_MAX) begin
            hold_count <= pwdata[8:0];
          end
        end
        THS_IRQM_ADDR: irq_mask <= pwdata[THS_IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // sticky events: a set in the clearing cycle wins
  always_comb begin
    irq_ev = '0;
    irq_ev[THS_IRQ_HOLD]  = (state == THS_TRACK) && (next_state == THS_HOLD);
    irq_ev[THS_IRQ_TRACK] = (state == THS_HOLD) && (next_state == THS_TRACK);
    irq_ev[THS_IRQ_ERR]   = cfg_bad && !cfg_bad_q;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_stat <= '0;
      irq_o    <= 1'b0;
    end else begin
      if (wr && paddr == THS_IRQS_ADDR) begin
        irq_stat <= (irq_stat & ~pwdata[THS_IRQ_W-1:0]) | irq_ev;
      end else begin
        irq_stat <= irq_stat | irq_ev;
      end
      irq_o <= |((irq_stat | irq_ev) & irq_mask);
    end
  end

  // checks next to the logic they guard
  property p_release;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    op == THS_OP_NONE |=> !hold_o && !bus_trig_oe_o && !counter_reserved_o
      && !scan_counter_output_oe_o && !external_hold_input_oe_o;
  endproperty
  a_release: assert property (p_release) else $error("outputs not released");

  property p_single_level;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    active && op == THS_OP_SINGLE |=> hold_o == $past(ctl);
  endproperty
  a_single_level: assert property (p_single_level) else $error("hold not level");

  property p_scan_enter;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    active && op == THS_OP_SCAN && state == THS_TRACK && ctl_rise
      |=> hold_o && remain == $past(hold_count);
  endproperty
  a_scan_enter: assert property (p_scan_enter) else $error("no hold on edge");

  property p_fwd_local;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    active && send == THS_SEND_LOC && src == THS_SRC_BUS |=> scan_counter_output_oe_o
      && external_hold_input_oe_o && external_hold_input_o == $past(ctl);
  endproperty
  a_fwd_local: assert property (p_fwd_local) else $error("local forward missing");

  property p_one_driver;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    op != THS_OP_NONE && send == THS_SEND_BUS && src != THS_SRC_BUS && busy_s
      |=> !bus_trig_oe_o && (irq_stat[THS_IRQ_ERR] || $past(cfg_bad_q)); // cleared only if old
  endproperty
  a_one_driver: assert property (p_one_driver) else $error("second bus driver");

  property p_count_track;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    active && op == THS_OP_SCAN && !simple && state == THS_HOLD && ent_fall
      && remain == THS_HCNT_MIN |=> !hold_o ##1 !hold_o || $past(ctl_rise);
  endproperty
  a_count_track: assert property (p_count_track) else $error("no track after count");

  property p_simple_ext;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    op != THS_OP_NONE && simple && src == THS_SRC_EXT |=> !hold_o && !counter_reserved_o;
  endproperty
  a_simple_ext: assert property (p_simple_ext) else $error("external on simple host");

  property p_scan_start;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    active && op == THS_OP_SCAN && src == THS_SRC_EXT && ctl_rise
      |=> scan_start_o && scan_clk_o ##1 !scan_start_o;
  endproperty
  a_scan_start: assert property (p_scan_start) else $error("scan start missing");

endmodule // ths_top

// ### dv/ths_host_model.sv
/*
  ths_host_model: host counter and scan-list sequencer facing the sequencer.
  Assumes its tasks are called just after a rising edge of clk_sys_i.
*/
module ths_host_model (
  // clock
  input  wire logic clk_sys_i,
  // counter line as the sequencer drives it
  input  wire logic ctr_oe_i,
  input  wire logic ctr_drv_i,
  // levels toward the sequencer
  output logic      ctr_line_o,
  output logic      entry_enable_o,
  output logic      scan_done_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic ctr_lvl;

  // the sequencer wins the line while it drives it, else the host level shows
  assign ctr_line_o = ctr_oe_i ? ctr_drv_i : ctr_lvl;

  // idle levels at time zero
  initial begin
    ctr_lvl = 1'b0;
    entry_enable_o = 1'b0;
    scan_done_o = 1'b0;
  end

  // single mode: host steers track/hold by the counter level
  task set_level(input logic l);
    ctr_lvl <= l;
  endtask

  // scan start: short counter pulse at each interval
  task pulse();
    ctr_lvl <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    ctr_lvl <= 1'b0;
  endtask

  // one scan-list entry, held for n cycles; the fall marks its expiry
  task entry(input int n);
    entry_enable_o <= 1'b1;
    repeat (n) @(posedge clk_sys_i);
    entry_enable_o <= 1'b0;
    @(posedge clk_sys_i);
  endtask

  // end of a scan interval for the simple host
  task done();
    scan_done_o <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    scan_done_o <= 1'b0;
  endtask
endmodule // ths_host_model

// ### dv/tb.sv
/*
  tb: self-checking bench for ths_top over APB and its pins.
  Assumes the three-edge pin latency and two-edge APB answer of the design.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ths_pkg::*;

  logic        clk_sys_i = 1'b0;
  logic        rst_n_i;
  logic        psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic        pready, pslverr, e;
  logic        ctr_i, ctr_o, ctr_oe, ctr_rsv, ext_o, ext_oe, bt_o, bt_oe;
  logic        ext_lvl, bt_lvl, bt_busy;
  logic        ent, sdone, sclk, sstart, hold, irq, seen;
  int          n_fail = 0, comparisons = 0, cyc_cnt = 0;

  // 20 MHz clock
  always #25 clk_sys_i = ~clk_sys_i;

  ths_top uut (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .scan_counter_output_i(ctr_i),
    .scan_counter_output_o(ctr_o), .scan_counter_output_oe_o(ctr_oe),
    .counter_reserved_o(ctr_rsv),
    .external_hold_input_i(ext_oe ? ext_o : ext_lvl),
    .external_hold_input_o(ext_o), .external_hold_input_oe_o(ext_oe),
    .bus_trig_i(bt_oe ? bt_o : bt_lvl), .bus_trig_busy_i(bt_busy),
    .bus_trig_o(bt_o), .bus_trig_oe_o(bt_oe), .entry_enable_i(ent),
    .scan_done_i(sdone), .scan_clk_o(sclk), .scan_start_o(sstart),
    .hold_o(hold), .irq_o(irq));

  ths_host_model host (
    .clk_sys_i(clk_sys_i), .ctr_oe_i(ctr_oe), .ctr_drv_i(ctr_o),
    .ctr_line_o(ctr_i), .entry_enable_o(ent), .scan_done_o(sdone));

  task final_report();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge clk_sys_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 3000) begin
      n_fail = n_fail + 1;
      final_report();
    end
  end

  task chk(input string nm, input logic [31:0] ex, input logic [31:0] g);
    comparisons++;
    if (g !== ex) begin
      n_fail++;
      $display("Error %s expected %0h seen %0h", nm, ex, g);
    end
  endtask

  // one APB transfer; request held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n == 20) chk("pready", 1, 0);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge keeps a following setup from reassigning psel in this step
    @(posedge clk_sys_i);
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] ex, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, ex, q);
  endtask

  // pin paths answer three edges after a change; six leaves a margin
  task settle();
    repeat (6) @(posedge clk_sys_i);
  endtask

  initial begin
    // idle bus and pin levels while reset is held
    rst_n_i <= 1'b0;
    {psel, penable, pwrite, ext_lvl, bt_lvl, bt_busy} <= 6'h00;
    paddr <= 8'h00;
    pwdata <= 32'h00000000;
    repeat (20) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    // reset values and an unmapped read
    rd(THS_CTRL_ADDR, 32'h0, "ctrl");
    rd(THS_HCNT_ADDR, 32'h1, "hcnt");
    rd(THS_IRQM_ADDR, 32'h0, "irqm");
    rd(8'h20, 32'h0, "unmapped");
    chk("pslverr", 1, e);
    // hold entry count limits
    wr(THS_HCNT_ADDR, 32'h100);
    wr(THS_HCNT_ADDR, 32'h0);
    wr(THS_HCNT_ADDR, 32'h101);
    rd(THS_HCNT_ADDR, 32'h100, "hcnt_lim");
    // single mode, counter source, hold interrupt
    wr(THS_IRQM_ADDR, 32'h1);
    wr(THS_CTRL_ADDR, 32'h01);
    host.set_level(1'b1);
    settle();
    chk("hold_single", 1, hold);
    chk("ctr_rsv", 1, ctr_rsv);
    chk("irq", 1, irq);
    wr(THS_IRQS_ADDR, 32'h1);
    @(posedge clk_sys_i);
    chk("irq_clr", 0, irq);
    host.set_level(1'b0);
    settle();
    chk("track_single", 0, hold);
    // backplane source relayed to counter line and pin
    wr(THS_CTRL_ADDR, 32'h19);
    bt_lvl <= 1'b1;
    settle();
    chk("hold_bus", 1, hold);
    chk("ctr_fwd", 2'h3, {ctr_oe, ctr_o});
    chk("ext_fwd", 2'h3, {ext_oe, ext_o});
    // operation none with other fields set releases everything
    wr(THS_CTRL_ADDR, 32'h18);
    settle();
    chk("released", 6'h0, {ctr_oe, ext_oe, bt_oe, ctr_rsv, hold, sclk});
    bt_lvl <= 1'b0;
    // forward onto the backplane, then a second driver appears
    wr(THS_CTRL_ADDR, 32'h21);
    host.set_level(1'b1);
    settle();
    chk("bt_drive", 2'h3, {bt_oe, bt_o});
    bt_busy <= 1'b1;
    settle();
    chk("bt_contend", 2'h0, {bt_oe, ctr_rsv});
    apb(1'b0, THS_IRQS_ADDR, 32'h0);
    chk("err_irq", 1, q[THS_IRQ_ERR]);
    bt_busy <= 1'b0;
    host.set_level(1'b0);
    // scan mode, external pin, two entries before track
    wr(THS_HCNT_ADDR, 32'h2);
    wr(THS_CTRL_ADDR, 32'h16);
    ext_lvl <= 1'b1;
    seen = 1'b0;
    repeat (6) begin
      @(posedge clk_sys_i);
      seen = seen | sstart;
    end
    chk("scan_start", 1, seen);
    chk("scan_hold", 3'h7, {hold, sclk, ctr_o});
    ext_lvl <= 1'b0;
    host.entry(4);
    settle();
    chk("hold_1st", 1, hold);
    host.entry(4);
    settle();
    chk("track_2nd", 0, hold);
    // simple host: track at interval end, external source refused
    wr(THS_CTRL_ADDR, 32'h42);
    host.pulse();
    settle();
    chk("simple_hold", 1, hold);
    host.done();
    settle();
    chk("simple_track", 0, hold);
    wr(THS_CTRL_ADDR, 32'h46);
    settle();
    apb(1'b0, THS_STAT_ADDR, 32'h0);
    chk("simple_ext_bad", 1, q[THS_STAT_BAD]);
    final_report();
  end
endmodule // tb
